//--- rtl/iocc_pkg.sv
// Shared constants for the channel control-state block
package iocc_pkg;
  // Register byte offsets
  localparam logic [7:0] CMD_OFS      = 8'h00;
  localparam logic [7:0] JUMP_OFS     = 8'h04;
  localparam logic [7:0] STAT_REQ_OFS = 8'h08;
  localparam logic [7:0] CHAN_BASE    = 8'h40;
  // Command register fields
  localparam int OP_LSB   = 0;
  localparam int OP_W     = 4;
  localparam int CHAN_LSB = 8;
  // Channel flag word bit positions
  localparam int FP_BIT = 0;
  localparam int FF_BIT = 1;
  localparam int SE_BIT = 2;
  localparam int SW_BIT = 3;
  localparam int RE_BIT = 4;
  localparam int RW_BIT = 5;
  localparam int OP_BIT = 6;
  localparam int IP_BIT = 7;
  // Response codes and the odd quarter-word select
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] QSEL_ODD    = 2'h1;
  // Channel commands
  typedef enum logic [3:0] {
    load_function_cmd         = 4'h1,
    load_function_watched_cmd = 4'h2,
    load_send_cmd             = 4'h3,
    load_send_watched_cmd     = 4'h4,
    load_receive_cmd          = 4'h5,
    load_receive_watched_cmd  = 4'h6,
    stop_send_cmd             = 4'h7,
    stop_receive_cmd          = 4'h8,
    jump_if_function_forced   = 4'h9,
    jump_if_send_engaged      = 4'ha,
    jump_if_receive_engaged   = 4'hb
  } iocc_cmd_t;
  // Service kinds from the timing chain
  typedef enum logic [1:0] {
    svc_sim_out = 2'h1,
    svc_out     = 2'h2,
    svc_in      = 2'h3
  } iocc_svc_t;
endpackage

//--- rtl/iocc_top.sv
// Per-channel control flags, request gating and monitor interrupt arbitration
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Each channel keeps eight flags: pending, forced, send/receive engaged and watch, output/input monitor interrupt.
// - Stop-receive clears receive-engaged and receive-watch.
// - Plain receive-load clears receive-watch only; receive-engaged stays set.
// - Stop-send clears send-engaged and send-watch.
// - Plain send-load clears send-watch only; send-engaged stays set.
// - Clearing a watch flag by command raises no monitor interrupt.
// - A monitor interrupt already in flight survives a later watch clear.
// - Function loads set pending and forced; serving the function word clears forced.
// - One function word per load, only when descriptor count is nonzero.
// - Function loads leave send-engaged and send-watch untouched.
// - Send loads set send-engaged; stop or terminal output clears it.
// - Receive loads set receive-engaged; stop or terminal input clears it.
// - Quarter-word output count 2 to 1 with select 01/11 ends send too.
// - Terminal clear of a watched engaged flag raises the monitor interrupt.
// - Taking the input monitor interrupt clears receive-watch.
// - Input monitor beats output monitor; lowest channel first.
// - Function-test jump taken when function-forced is set.
// - Send-busy jump taken when send-engaged is set.
// - Receive-busy jump taken when receive-engaged is set.
module iocc_top #(
  parameter int NCH = 16,
  parameter int CW  = 4
) (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           sys_rst,
  // AXI4-Lite slave
  input  wire logic [7:0]     s_axi_awaddr,
  input  wire logic           s_axi_awvalid,
  output logic                s_axi_awready,
  input  wire logic [31:0]    s_axi_wdata,
  input  wire logic [3:0]     s_axi_wstrb,
  input  wire logic           s_axi_wvalid,
  output logic                s_axi_wready,
  output logic [1:0]          s_axi_bresp,
  output logic                s_axi_bvalid,
  input  wire logic           s_axi_bready,
  input  wire logic [7:0]     s_axi_araddr,
  input  wire logic           s_axi_arvalid,
  output logic                s_axi_arready,
  output logic [31:0]         s_axi_rdata,
  output logic [1:0]          s_axi_rresp,
  output logic                s_axi_rvalid,
  input  wire logic           s_axi_rready,
  // Peripheral request pins
  input  wire logic [NCH-1:0] output_word_request,
  input  wire logic [NCH-1:0] input_word_request,
  input  wire logic [NCH-1:0] status_request_line,
  // Gated requests to the timing chain
  output logic [NCH-1:0]      out_req_gated,
  output logic [NCH-1:0]      in_req_gated,
  output logic [NCH-1:0]      fn_req,
  output logic [NCH-1:0]      stat_req,
  // Service report from the timing chain
  input  wire logic           svc_valid,
  input  wire logic [1:0]     svc_kind,
  input  wire logic [CW-1:0]  svc_chan,
  input  wire logic           svc_terminal,
  input  wire logic           svc_count_zero,
  input  wire logic           svc_quarter,
  input  wire logic           svc_step_2to1,
  input  wire logic [1:0]     svc_qsel,
  output logic                fn_send,
  // Monitor interrupt request
  output logic                mon_irq_valid,
  output logic                mon_irq_is_input,
  output logic [CW-1:0]       mon_irq_chan,
  input  wire logic           mon_irq_ack
);
  // AXI state
  logic            awready_reg, awready_next, wready_reg, wready_next;
  logic            bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [1:0]      bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [7:0]      awaddr_reg, awaddr_next;
  logic [31:0]     wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic            commit, cmd_fire;
  iocc_pkg::iocc_cmd_t cmd_op;
  logic [CW-1:0]   cmd_chan;
  logic            jump_reg, jump_next;
  // Flags, one bit per channel
  logic [NCH-1:0]  fp_reg, ff_reg, se_reg, sw_reg, re_reg, rw_reg, ip_reg, op_reg;
  logic [NCH-1:0]  fp_next, ff_next, se_next, sw_next, re_next, rw_next, ip_next, op_next;
  // Synchronisers and request outputs
  logic [NCH-1:0]  out_s1_reg, out_s2_reg, in_s1_reg, in_s2_reg, st_s1_reg, st_s2_reg;
  logic [NCH-1:0]  out_req_next, in_req_next;
  logic            fn_send_next, irq_v_next, irq_in_next;
  logic [CW-1:0]   irq_ch_next;

  assign commit   = !awready_reg && !wready_reg && !bvalid_reg;
  assign cmd_fire = commit && awaddr_reg == iocc_pkg::CMD_OFS && 32'(wdata_reg[iocc_pkg::CHAN_LSB +: 4]) < NCH;
  assign cmd_op   = iocc_pkg::iocc_cmd_t'(wdata_reg[iocc_pkg::OP_LSB +: iocc_pkg::OP_W]);
  assign cmd_chan = wdata_reg[iocc_pkg::CHAN_LSB +: CW];

  // Bus slave next state
  always_comb
  begin
    awready_next = awready_reg;
    wready_next  = wready_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    jump_next    = jump_reg;
    if (awready_reg && s_axi_awvalid)
    begin
      awready_next = 1'b0;
      awaddr_next  = s_axi_awaddr;
    end
    if (wready_reg && s_axi_wvalid)
    begin
      wready_next = 1'b0;
      wdata_next  = s_axi_wdata;
    end
    if (commit)
    begin
      bvalid_next = 1'b1;
      bresp_next  = (awaddr_reg == iocc_pkg::CMD_OFS) ? iocc_pkg::RESP_OKAY : iocc_pkg::RESP_SLVERR;
    end
    if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next  = 1'b0;
      awready_next = 1'b1;
      wready_next  = 1'b1;
    end
    if (cmd_fire)
    begin
      unique case (cmd_op)
        iocc_pkg::jump_if_function_forced: jump_next = ff_reg[cmd_chan];
        iocc_pkg::jump_if_send_engaged:    jump_next = se_reg[cmd_chan];
        iocc_pkg::jump_if_receive_engaged: jump_next = re_reg[cmd_chan];
        default:                           jump_next = jump_reg;
      endcase
    end
    if (arready_reg && s_axi_arvalid)
    begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rresp_next   = iocc_pkg::RESP_OKAY;
      rdata_next   = 32'h0000_0000;
      if (s_axi_araddr == iocc_pkg::JUMP_OFS)
        rdata_next[0] = jump_reg;
      else if (s_axi_araddr == iocc_pkg::STAT_REQ_OFS)
        rdata_next[NCH-1:0] = st_s2_reg;
      else if (s_axi_araddr >= iocc_pkg::CHAN_BASE && s_axi_araddr[1:0] == 2'b00
               && s_axi_araddr[7:2] - iocc_pkg::CHAN_BASE[7:2] < NCH)
      begin
        rdata_next[iocc_pkg::FP_BIT] = fp_reg[CW'(s_axi_araddr[7:2] - iocc_pkg::CHAN_BASE[7:2])];
        rdata_next[iocc_pkg::FF_BIT] = ff_reg[CW'(s_axi_araddr[7:2] - iocc_pkg::CHAN_BASE[7:2])];
        rdata_next[iocc_pkg::SE_BIT] = se_reg[CW'(s_axi_araddr[7:2] - iocc_pkg::CHAN_BASE[7:2])];
        rdata_next[iocc_pkg::SW_BIT] = sw_reg[CW'(s_axi_araddr[7:2] - iocc_pkg::CHAN_BASE[7:2])];
        rdata_next[iocc_pkg::RE_BIT] = re_reg[CW'(s_axi_araddr[7:2] - iocc_pkg::CHAN_BASE[7:2])];
        rdata_next[iocc_pkg::RW_BIT] = rw_reg[CW'(s_axi_araddr[7:2] - iocc_pkg::CHAN_BASE[7:2])];
        rdata_next[iocc_pkg::OP_BIT] = op_reg[CW'(s_axi_araddr[7:2] - iocc_pkg::CHAN_BASE[7:2])];
        rdata_next[iocc_pkg::IP_BIT] = ip_reg[CW'(s_axi_araddr[7:2] - iocc_pkg::CHAN_BASE[7:2])];
      end
      else if (s_axi_araddr != iocc_pkg::CMD_OFS)
        rresp_next = iocc_pkg::RESP_SLVERR;
    end
    if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= iocc_pkg::RESP_OKAY;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= iocc_pkg::RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
      jump_reg    <= 1'b0;
    end
    else
    begin
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
      jump_reg    <= jump_next;
    end
  end

  // Per-channel flag next state: ack, then timing chain, then command
  for (genvar ch = 0; ch < NCH; ch++)
  begin : g_chan
    logic cmd_hit, svc_hit, ack_hit, term_out, term_in;
    assign cmd_hit  = cmd_fire && cmd_chan == CW'(ch);
    assign svc_hit  = svc_valid && svc_chan == CW'(ch);
    assign ack_hit  = mon_irq_ack && mon_irq_valid && mon_irq_chan == CW'(ch);
    assign term_out = svc_hit && svc_kind == iocc_pkg::svc_out && se_reg[ch]
                      && (svc_terminal || (svc_quarter && svc_step_2to1 && svc_qsel[0] == iocc_pkg::QSEL_ODD[0]));
    assign term_in  = svc_hit && svc_kind == iocc_pkg::svc_in && re_reg[ch] && svc_terminal;
    always_comb
    begin
      fp_next[ch] = fp_reg[ch];
      ff_next[ch] = ff_reg[ch];
      se_next[ch] = se_reg[ch];
      sw_next[ch] = sw_reg[ch];
      re_next[ch] = re_reg[ch];
      rw_next[ch] = rw_reg[ch];
      ip_next[ch] = ip_reg[ch];
      op_next[ch] = op_reg[ch];
      if (ack_hit && mon_irq_is_input)
      begin
        ip_next[ch] = 1'b0;
        rw_next[ch] = 1'b0;
      end
      if (ack_hit && !mon_irq_is_input)
      begin
        op_next[ch] = 1'b0;
        sw_next[ch] = 1'b0;
      end
      if (svc_hit && svc_kind == iocc_pkg::svc_sim_out)
      begin
        fp_next[ch] = 1'b0;
        ff_next[ch] = 1'b0;
      end
      if (term_out)
      begin
        se_next[ch] = 1'b0;
        op_next[ch] = op_next[ch] | sw_reg[ch];
      end
      if (term_in)
      begin
        re_next[ch] = 1'b0;
        ip_next[ch] = ip_next[ch] | rw_reg[ch];
      end
      // Commands never touch pending interrupts
      if (cmd_hit)
      begin
        unique case (cmd_op)
          iocc_pkg::load_function_cmd, iocc_pkg::load_function_watched_cmd:
          begin
            fp_next[ch] = 1'b1;
            ff_next[ch] = 1'b1;
          end
          iocc_pkg::load_send_cmd:
          begin
            se_next[ch] = 1'b1;
            sw_next[ch] = 1'b0;
          end
          iocc_pkg::load_send_watched_cmd:
          begin
            se_next[ch] = 1'b1;
            sw_next[ch] = 1'b1;
          end
          iocc_pkg::load_receive_cmd:
          begin
            re_next[ch] = 1'b1;
            rw_next[ch] = 1'b0;
          end
          iocc_pkg::load_receive_watched_cmd:
          begin
            re_next[ch] = 1'b1;
            rw_next[ch] = 1'b1;
          end
          iocc_pkg::stop_send_cmd:
          begin
            se_next[ch] = 1'b0;
            sw_next[ch] = 1'b0;
          end
          iocc_pkg::stop_receive_cmd:
          begin
            re_next[ch] = 1'b0;
            rw_next[ch] = 1'b0;
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // Request gating, function send and interrupt choice
  always_comb
  begin
    out_req_next = out_s2_reg & se_reg;
    in_req_next  = in_s2_reg & re_reg;
    fn_send_next = svc_valid && svc_kind == iocc_pkg::svc_sim_out && fp_reg[svc_chan] && !svc_count_zero;
    irq_v_next   = 1'b0;
    irq_in_next  = 1'b0;
    irq_ch_next  = '0;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (op_next[i] && !irq_in_next)
      begin
        irq_v_next  = 1'b1;
        irq_ch_next = CW'(i);
      end
    end
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (ip_next[i])
      begin
        irq_v_next  = 1'b1;
        irq_in_next = 1'b1;
        irq_ch_next = CW'(i);
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      {fp_reg, ff_reg, se_reg, sw_reg, re_reg, rw_reg, ip_reg, op_reg} <= '0;
      {out_s1_reg, out_s2_reg, in_s1_reg, in_s2_reg, st_s1_reg, st_s2_reg} <= '0;
      out_req_gated    <= '0;
      in_req_gated     <= '0;
      fn_send          <= 1'b0;
      mon_irq_valid    <= 1'b0;
      mon_irq_is_input <= 1'b0;
      mon_irq_chan     <= '0;
    end
    else
    begin
      fp_reg <= fp_next;
      ff_reg <= ff_next;
      se_reg <= se_next;
      sw_reg <= sw_next;
      re_reg <= re_next;
      rw_reg <= rw_next;
      ip_reg <= ip_next;
      op_reg <= op_next;
      out_s1_reg <= output_word_request;
      out_s2_reg <= out_s1_reg;
      in_s1_reg  <= input_word_request;
      in_s2_reg  <= in_s1_reg;
      st_s1_reg  <= status_request_line;
      st_s2_reg  <= st_s1_reg;
      out_req_gated    <= out_req_next;
      in_req_gated     <= in_req_next;
      fn_send          <= fn_send_next;
      mon_irq_valid    <= irq_v_next;
      mon_irq_is_input <= irq_in_next;
      mon_irq_chan     <= irq_ch_next;
    end
  end

  assign fn_req        = fp_reg;
  assign stat_req      = st_s2_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  // Checks
  chk_stop_recv_clears: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_fire && cmd_op == iocc_pkg::stop_receive_cmd |=> !re_reg[$past(cmd_chan)] && !rw_reg[$past(cmd_chan)])
    else $error("stop receive left flags set");
  chk_load_recv_plain: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_fire && cmd_op == iocc_pkg::load_receive_cmd |=> re_reg[$past(cmd_chan)] && !rw_reg[$past(cmd_chan)])
    else $error("plain receive load wrong");
  chk_stop_send_clears: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_fire && cmd_op == iocc_pkg::stop_send_cmd |=> !se_reg[$past(cmd_chan)] && !sw_reg[$past(cmd_chan)])
    else $error("stop send left flags set");
  chk_load_send_plain: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_fire && cmd_op == iocc_pkg::load_send_cmd |=> se_reg[$past(cmd_chan)] && !sw_reg[$past(cmd_chan)])
    else $error("plain send load wrong");
  chk_stop_no_irq: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_fire && cmd_op == iocc_pkg::stop_receive_cmd && !ip_reg[cmd_chan] && !svc_valid
    |=> !ip_reg[$past(cmd_chan)])
    else $error("stop raised a monitor interrupt");
  chk_fn_load_sets: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_fire && cmd_op == iocc_pkg::load_function_watched_cmd |=> fp_reg[$past(cmd_chan)] && ff_reg[$past(cmd_chan)])
    else $error("function load flags not set");
  chk_fn_send_count: assert property (@(posedge clk) disable iff (sys_rst)
    fn_send |-> $past(svc_valid) && !$past(svc_count_zero))
    else $error("function word with zero count");
  chk_term_in_irq: assert property (@(posedge clk) disable iff (sys_rst)
    svc_valid && svc_kind == iocc_pkg::svc_in && re_reg[svc_chan] && rw_reg[svc_chan] && svc_terminal
    |=> ip_reg[$past(svc_chan)] ##1 mon_irq_valid)
    else $error("terminal input raised no interrupt");
  chk_input_first: assert property (@(posedge clk) disable iff (sys_rst)
    mon_irq_valid && !mon_irq_is_input |-> ip_reg == '0)
    else $error("output interrupt beat input");
  chk_jump_forced: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_fire && cmd_op == iocc_pkg::jump_if_function_forced |=> jump_reg == $past(ff_reg[cmd_chan]))
    else $error("function jump result wrong");
endmodule

`default_nettype wire

//--- test/iocc_periph.sv
// Peripheral subsystem model that raises the channel request lines
`timescale 1ns/10ps
`default_nettype none
module iocc_periph #(
  parameter int NCH = 4
) (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           sys_rst,
  // Requests wanted by the bench and reply lag
  input  wire logic [NCH-1:0] want_out,
  input  wire logic [NCH-1:0] want_in,
  input  wire logic [NCH-1:0] want_stat,
  input  wire logic [1:0]     lag,
  // Request lines to the block
  output logic [NCH-1:0]      output_word_request,
  output logic [NCH-1:0]      input_word_request,
  output logic [NCH-1:0]      status_request_line
);
  logic [3*NCH-1:0] pipe_reg  [4];
  logic [3*NCH-1:0] pipe_next [4];
  always_comb
  begin
    pipe_next[0] = {want_out, want_in, want_stat};
    for (int i = 1; i < 4; i++)
      pipe_next[i] = pipe_reg[i-1];
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pipe_reg <= '{default: '0};
    else
      pipe_reg <= pipe_next;
  end
  // Ready for an output word only when asked, never for a function word
  assign output_word_request = pipe_reg[lag][3*NCH-1:2*NCH];
  // Input and status requests stand while their words are presented
  assign input_word_request  = pipe_reg[lag][2*NCH-1:NCH];
  assign status_request_line = pipe_reg[lag][NCH-1:0];
endmodule
`default_nettype wire

//--- test/io_channel_control_state_bench.sv
// Self-checking bench for the channel control-state block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; $display("Error %s expected %h seen %h", nm, e, g); end end
module io_channel_control_state_bench;
  localparam int NCH = 4;
  localparam int CW  = 2;
  localparam int FP = iocc_pkg::FP_BIT, FF = iocc_pkg::FF_BIT, SE = iocc_pkg::SE_BIT, SW = iocc_pkg::SW_BIT;
  localparam int RE = iocc_pkg::RE_BIT, RW = iocc_pkg::RW_BIT, OP = iocc_pkg::OP_BIT, IP = iocc_pkg::IP_BIT;
  logic           clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic           s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]     s_axi_awaddr, s_axi_araddr;
  logic [31:0]    s_axi_wdata, s_axi_rdata;
  logic [3:0]     s_axi_wstrb;
  logic [1:0]     s_axi_bresp, s_axi_rresp, svc_kind, svc_qsel, lag;
  logic [NCH-1:0] output_word_request, input_word_request, status_request_line, want_out, want_in;
  logic [NCH-1:0] out_req_gated, in_req_gated, fn_req, stat_req, want_stat;
  logic           svc_valid, svc_terminal, svc_count_zero, svc_quarter, svc_step_2to1, fn_send;
  logic [CW-1:0]  svc_chan, mon_irq_chan;
  logic           mon_irq_valid, mon_irq_is_input, mon_irq_ack;
  logic [7:0]     mf [NCH];
  int             failures, checks;

  iocc_top #(.NCH(NCH), .CW(CW)) i_iocc_top (
    .clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .output_word_request(output_word_request), .input_word_request(input_word_request),
    .status_request_line(status_request_line), .out_req_gated(out_req_gated),
    .in_req_gated(in_req_gated), .fn_req(fn_req), .stat_req(stat_req), .svc_valid(svc_valid),
    .svc_kind(svc_kind), .svc_chan(svc_chan), .svc_terminal(svc_terminal),
    .svc_count_zero(svc_count_zero), .svc_quarter(svc_quarter), .svc_step_2to1(svc_step_2to1),
    .svc_qsel(svc_qsel), .fn_send(fn_send), .mon_irq_valid(mon_irq_valid),
    .mon_irq_is_input(mon_irq_is_input), .mon_irq_chan(mon_irq_chan), .mon_irq_ack(mon_irq_ack));

  iocc_periph #(.NCH(NCH)) i_iocc_periph (
    .clk(clk), .sys_rst(sys_rst), .want_out(want_out), .want_in(want_in), .want_stat(want_stat),
    .lag(lag), .output_word_request(output_word_request), .input_word_request(input_word_request),
    .status_request_line(status_request_line));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic bail;
    failures++;
    $display("Error bus_wait expected answer seen none");
    summarize();
  endtask

  // Address and data offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_go, w_go, b_go;
    int n;
    r = 2'h3;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(negedge clk);
      aw_go = s_axi_awvalid & s_axi_awready;
      w_go = s_axi_wvalid & s_axi_wready;
      b_go = s_axi_bvalid;
      if (b_go)
        r = s_axi_bresp;
      @(posedge clk);
      if (aw_go)
        s_axi_awvalid <= 1'b0;
      if (w_go)
        s_axi_wvalid <= 1'b0;
      if (b_go)
        break;
    end
    s_axi_bready <= 1'b0;
    if (n == 100)
      bail();
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_go, r_go;
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(negedge clk);
      ar_go = s_axi_arvalid & s_axi_arready;
      r_go = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ar_go)
        s_axi_arvalid <= 1'b0;
      if (r_go)
        break;
    end
    s_axi_rready <= 1'b0;
    if (n == 100)
      bail();
  endtask

  function automatic logic [7:0] cmd_next(input logic [7:0] f, input int op);
    case (op)
      1, 2: {f[FP], f[FF]} = 2'b11;
      3: {f[SE], f[SW]} = 2'b10;
      4: {f[SE], f[SW]} = 2'b11;
      5: {f[RE], f[RW]} = 2'b10;
      6: {f[RE], f[RW]} = 2'b11;
      7: {f[SE], f[SW]} = 2'b00;
      8: {f[RE], f[RW]} = 2'b00;
      default: ;
    endcase
    return f;
  endfunction

  // Input beats output, lowest channel first
  function automatic logic [CW+1:0] irq_exp();
    logic [CW+1:0] e;
    e = '0;
    for (int i = NCH - 1; i >= 0; i--)
      if (mf[i][OP])
        e = {2'b10, CW'(i)};
    for (int i = NCH - 1; i >= 0; i--)
      if (mf[i][IP])
        e = {2'b11, CW'(i)};
    return e;
  endfunction

  task automatic cmd(input int op, input int ch);
    logic [1:0] r;
    axi_write(iocc_pkg::CMD_OFS, (32'(ch) << iocc_pkg::CHAN_LSB) | 32'(op), r);
    `CHK("cmd_resp", iocc_pkg::RESP_OKAY, r)
    if (ch < NCH)
      mf[ch] = cmd_next(mf[ch], op);
  endtask

  task automatic jump(input int op, input int ch);
    logic [31:0] d;
    logic [1:0] r;
    logic x;
    x = (op == 9) ? mf[ch][FF] : (op == 10) ? mf[ch][SE] : mf[ch][RE];
    cmd(op, ch);
    axi_read(iocc_pkg::JUMP_OFS, d, r);
    `CHK("jump", {iocc_pkg::RESP_OKAY, 31'h0000_0000, x}, {r, d})
  endtask

  task automatic svc(input int k, input int ch, input logic t, cz, q, st, input logic [1:0] qs);
    logic [7:0] f;
    logic xs;
    int sends;
    f = mf[ch];
    xs = 1'b0;
    sends = 0;
    @(posedge clk);
    {svc_valid, svc_kind, svc_chan, svc_terminal} <= {1'b1, 2'(k), CW'(ch), t};
    {svc_count_zero, svc_quarter, svc_step_2to1, svc_qsel} <= {cz, q, st, qs};
    @(posedge clk);
    svc_valid <= 1'b0;
    case (k)
      1: {xs, f[FP], f[FF]} = {f[FP] & ~cz, 2'b00};
      2: if (f[SE] && (t || (q && st && qs[0]))) {f[SE], f[OP]} = {1'b0, f[OP] | f[SW]};
      default: if (f[RE] && t) {f[RE], f[IP]} = {1'b0, f[IP] | f[RW]};
    endcase
    mf[ch] = f;
    repeat (4)
    begin
      @(negedge clk);
      if (fn_send !== 1'b0)
        sends++;
    end
    `CHK("fn_send", 32'(xs), 32'(sends))
  endtask

  task automatic ack;
    logic [CW+1:0] e;
    e = irq_exp();
    if (!e[CW+1])
      return;
    @(posedge clk);
    mon_irq_ack <= 1'b1;
    @(posedge clk);
    mon_irq_ack <= 1'b0;
    if (e[CW])
      {mf[e[CW-1:0]][IP], mf[e[CW-1:0]][RW]} = 2'b00;
    else
      {mf[e[CW-1:0]][OP], mf[e[CW-1:0]][SW]} = 2'b00;
  endtask

  task automatic check_all;
    logic [31:0] d;
    logic [1:0] r;
    logic [NCH-1:0] sv, rv, fv;
    logic [CW+1:0] e;
    @(posedge clk);
    want_out <= NCH'($urandom);
    want_in <= NCH'($urandom);
    want_stat <= NCH'($urandom);
    lag <= 2'($urandom);
    repeat (10) @(posedge clk);
    @(negedge clk);
    for (int i = 0; i < NCH; i++)
      {sv[i], rv[i], fv[i]} = {mf[i][SE], mf[i][RE], mf[i][FP]};
    e = irq_exp();
    `CHK("out_req_gated", want_out & sv, out_req_gated)
    `CHK("in_req_gated", want_in & rv, in_req_gated)
    `CHK("stat_req", want_stat, stat_req)
    `CHK("fn_req", fv, fn_req)
    `CHK("mon_irq_valid", e[CW+1], mon_irq_valid)
    if (e[CW+1])
      `CHK("mon_irq_src", e[CW:0], {mon_irq_is_input, mon_irq_chan})
    for (int i = 0; i < NCH; i++)
    begin
      axi_read(iocc_pkg::CHAN_BASE + 8'(4 * i), d, r);
      `CHK("chan_flags", {iocc_pkg::RESP_OKAY, 24'h00_0000, mf[i]}, {r, d})
    end
    axi_read(iocc_pkg::STAT_REQ_OFS, d, r);
    `CHK("stat_reg", {28'h000_0000, want_stat}, d)
  endtask

  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0000, 32'h0000_0000, 4'hf};
    {svc_valid, svc_kind, svc_chan, svc_terminal, svc_count_zero, svc_quarter} = '0;
    {svc_step_2to1, svc_qsel, mon_irq_ack, want_out, want_in, want_stat, lag} = '0;
    for (int i = 0; i < NCH; i++)
      mf[i] = 8'h00;
    failures = 0;
    checks = 0;
    sys_rst = 1'b1;
    void'($urandom(25));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    check_all();
    axi_read(8'h30, d, r);
    `CHK("unmapped_read", {iocc_pkg::RESP_SLVERR, 32'h0000_0000}, {r, d})
    axi_write(8'h30, 32'h0000_0614, r);
    `CHK("unmapped_write", iocc_pkg::RESP_SLVERR, r)
    // Watch cleared by stop, then an interrupt caught in flight
    cmd(6, 1);
    cmd(8, 1);
    check_all();
    cmd(4, 2);
    svc(2, 2, 1, 0, 0, 0, 2'h0);
    cmd(7, 2);
    cmd(6, 3);
    svc(3, 3, 1, 0, 0, 0, 2'h0);
    check_all();
    ack();
    check_all();
    ack();
    // Quarter-word end of send, select 10 then 01
    cmd(4, 1);
    svc(2, 1, 0, 0, 1, 1, 2'h2);
    svc(2, 1, 0, 0, 1, 1, 2'h1);
    cmd(4, 0);
    cmd(3, 0);
    cmd(6, 0);
    cmd(5, 0);
    check_all();
    // One function word per load, none at count zero
    cmd(2, 0);
    svc(1, 0, 0, 0, 0, 0, 2'h0);
    svc(1, 0, 0, 0, 0, 0, 2'h0);
    cmd(1, 0);
    svc(1, 0, 0, 1, 0, 0, 2'h0);
    cmd(5, NCH);
    for (int op = 9; op <= 11; op++)
      jump(op, 0);
    check_all();
    repeat (60)
    begin
      case ($urandom_range(0, 3))
        0: cmd($urandom_range(1, 8), $urandom_range(0, NCH));
        1: jump($urandom_range(9, 11), $urandom_range(0, NCH - 1));
        2: svc($urandom_range(1, 3), $urandom_range(0, NCH - 1), 1'($urandom), 1'($urandom),
               1'($urandom), 1'($urandom), 2'($urandom));
        default: ack();
      endcase
      check_all();
    end
    summarize();
  end
endmodule
`default_nettype wire
